// [rtl/tap_pulse_detector.sv]
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module tap_pulse_detector #(
  parameter int unsigned STEP_CYCLES = tap_pkg::BASE_STEP_CYCLES,
  parameter int unsigned ADDR_W = 8
)(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sample_valid,
  input wire logic signed [tap_pkg::SAMPLE_W-1:0] raw_x,
  input wire logic signed [tap_pkg::SAMPLE_W-1:0] raw_y,
  input wire logic signed [tap_pkg::SAMPLE_W-1:0] raw_z,
  input wire logic signed [tap_pkg::SAMPLE_W-1:0] hpf_x,
  input wire logic signed [tap_pkg::SAMPLE_W-1:0] hpf_y,
  input wire logic signed [tap_pkg::SAMPLE_W-1:0] hpf_z
);

  localparam int unsigned IW = tap_pkg::IDX_W;
  localparam int unsigned RW = tap_pkg::REG_W;

  if (ADDR_W < IW + tap_pkg::ADDR_LSB || STEP_CYCLES < 2)
  begin : g_chk
    $error("address too narrow or step too short");
  end

  // =====================================================================
  // registers
  logic [RW-1:0] cfg_r;
  logic [RW-1:0] src_r;
  logic [tap_pkg::THR_W-1:0] thr_r [3];
  logic [tap_pkg::CNT_W-1:0] tmlt_r;
  logic [tap_pkg::CNT_W-1:0] ltcy_r;
  logic [tap_pkg::CNT_W-1:0] wind_r;
  logic [RW-1:0] mode_r;

  // =====================================================================
  // bus slave, zero wait states
  logic acc;
  logic in_map;
  logic [IW-1:0] idx;
  logic wr_pend_r;
  logic [IW-1:0] wr_idx_r;
  logic [RW-1:0] rd_val;
  logic src_read;

  assign in_map = (haddr >> (IW + tap_pkg::ADDR_LSB)) == '0;
  assign acc = hsel && hready && htrans == tap_pkg::HTRANS_NONSEQ &&
    hsize == tap_pkg::HSIZE_WORD;
  assign idx = haddr[IW+tap_pkg::ADDR_LSB-1:tap_pkg::ADDR_LSB];
  assign src_read = acc && !hwrite && in_map && idx == tap_pkg::IDX_SOURCE;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= '0;
    end
    else
    begin
      wr_pend_r <= acc && hwrite && in_map;
      wr_idx_r <= idx;
    end
  end

  // a read right behind a write to the same word sees the new value
  always_comb
  begin
    unique case (idx)
      tap_pkg::IDX_CONFIG: rd_val = cfg_r;
      tap_pkg::IDX_SOURCE: rd_val = src_r;
      tap_pkg::IDX_THR_X: rd_val = {1'b0, thr_r[0]};
      tap_pkg::IDX_THR_Y: rd_val = {1'b0, thr_r[1]};
      tap_pkg::IDX_THR_Z: rd_val = {1'b0, thr_r[2]};
      tap_pkg::IDX_TIME_LIMIT: rd_val = tmlt_r;
      tap_pkg::IDX_LATENCY: rd_val = ltcy_r;
      tap_pkg::IDX_WINDOW: rd_val = wind_r;
      tap_pkg::IDX_MODE: rd_val = mode_r;
      default: rd_val = tap_pkg::RESET_VAL;
    endcase
    if (!in_map)
      rd_val = tap_pkg::RESET_VAL;
    else if (wr_pend_r && wr_idx_r == idx && idx != tap_pkg::IDX_SOURCE)
    begin
      if (idx == tap_pkg::IDX_CONFIG || idx == tap_pkg::IDX_TIME_LIMIT ||
        idx == tap_pkg::IDX_LATENCY || idx == tap_pkg::IDX_WINDOW ||
        idx == tap_pkg::IDX_MODE)
        rd_val = hwdata[RW-1:0];
      else if (idx >= tap_pkg::IDX_THR_X && idx <= tap_pkg::IDX_THR_Z)
        rd_val = {1'b0, hwdata[tap_pkg::THR_W-1:0]};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      hrdata <= '0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= (acc && !hwrite) ? {24'h000000, rd_val} : 32'h00000000;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      cfg_r <= tap_pkg::RESET_VAL;
      thr_r <= '{default: '0};
      tmlt_r <= tap_pkg::RESET_VAL;
      ltcy_r <= tap_pkg::RESET_VAL;
      wind_r <= tap_pkg::RESET_VAL;
      mode_r <= tap_pkg::RESET_VAL;
    end
    else if (wr_pend_r)
    begin
      unique case (wr_idx_r)
        tap_pkg::IDX_CONFIG: cfg_r <= hwdata[RW-1:0];
        tap_pkg::IDX_THR_X: thr_r[0] <= hwdata[tap_pkg::THR_W-1:0];
        tap_pkg::IDX_THR_Y: thr_r[1] <= hwdata[tap_pkg::THR_W-1:0];
        tap_pkg::IDX_THR_Z: thr_r[2] <= hwdata[tap_pkg::THR_W-1:0];
        tap_pkg::IDX_TIME_LIMIT: tmlt_r <= hwdata[RW-1:0];
        tap_pkg::IDX_LATENCY: ltcy_r <= hwdata[RW-1:0];
        tap_pkg::IDX_WINDOW: wind_r <= hwdata[RW-1:0];
        tap_pkg::IDX_MODE: mode_r <= hwdata[RW-1:0];
        default: ;
      endcase
    end
  end

  // =====================================================================
  // configuration fields
  logic abort_en;
  logic latch_en;
  logic hpf_en;
  logic [1:0] range_sel;
  logic [2:0] rate_sel;
  tap_pkg::pwr_type pwr_sel;
  logic [2:0] sp_en;
  logic [2:0] dp_en;

  assign abort_en = cfg_r[tap_pkg::CFG_ABORT];
  assign latch_en = cfg_r[tap_pkg::CFG_LATCH];
  assign hpf_en = mode_r[tap_pkg::MODE_HPF];
  assign range_sel = mode_r[tap_pkg::MODE_RANGE_LSB +: 2];
  assign rate_sel = mode_r[tap_pkg::MODE_RATE_LSB +: 3];
  assign pwr_sel = tap_pkg::pwr_type'(mode_r[tap_pkg::MODE_PWR_LSB +: 2]);
  for (genvar a = 0; a < 3; a++)
  begin : g_en
    assign sp_en[a] = cfg_r[2 * a + tap_pkg::EN_SINGLE];
    assign dp_en[a] = cfg_r[2 * a + tap_pkg::EN_DOUBLE];
  end

  // =====================================================================
  // per-axis threshold compare
  logic [2:0] above;
  logic [2:0] neg;
  logic signed [tap_pkg::SAMPLE_W-1:0] axis_in [3];

  always_comb
  begin
    axis_in[0] = hpf_en ? hpf_x : raw_x;
    axis_in[1] = hpf_en ? hpf_y : raw_y;
    axis_in[2] = hpf_en ? hpf_z : raw_z;
  end

  for (genvar a = 0; a < 3; a++)
  begin : g_axis
    tap_axis_compare u_cmp (
      .sample(axis_in[a]),
      .range_select(range_sel),
      .threshold(thr_r[a]),
      .above(above[a]),
      .negative(neg[a])
    );
  end

  // =====================================================================
  // step ticks: limit step, latency and window at twice that
  logic base_tick;
  logic [tap_pkg::MULT_W-1:0] pre_r;
  logic [tap_pkg::MULT_W-1:0] mult;
  logic lim_tick;
  logic half_r;
  logic long_tick;

  tap_step_divider #(
    .CYCLES(STEP_CYCLES)
  ) u_div (
    .mclk(mclk),
    .rstn(rstn),
    .tick(base_tick)
  );

  assign mult = tap_pkg::limit_step(rate_sel, pwr_sel, hpf_en);
  assign lim_tick = base_tick && pre_r >= mult - 1'b1;
  assign long_tick = lim_tick && half_r;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      pre_r <= '0;
      half_r <= 1'b0;
    end
    else if (base_tick)
    begin
      pre_r <= lim_tick ? '0 : pre_r + 1'b1;
      if (lim_tick)
        half_r <= !half_r;
    end
  end

  // =====================================================================
  // detection sequence
  tap_pkg::state_type state_r;
  logic [tap_pkg::CNT_W-1:0] cnt_r;
  logic [2:0] axes_r;
  logic [2:0] pol_r;
  logic lat_pulse_r;
  logic [2:0] watch;
  logic [2:0] hit;
  logic any_hit;
  logic ev;
  logic ev_dbl;
  logic [2:0] ev_axes;

  assign watch = sp_en | dp_en;
  assign hit = above & watch;
  assign any_hit = |hit;

  always_comb
  begin
    ev = 1'b0;
    ev_dbl = 1'b0;
    ev_axes = 3'b000;
    if (sample_valid && !any_hit)
    begin
      if (state_r == tap_pkg::ST_FIRST && (axes_r & sp_en) != 3'b000)
      begin
        ev = 1'b1;
        ev_axes = axes_r & sp_en;
      end
      else if (state_r == tap_pkg::ST_SECOND && (axes_r & dp_en) != 3'b000)
      begin
        ev = 1'b1;
        ev_dbl = 1'b1;
        ev_axes = axes_r & dp_en;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state_r <= tap_pkg::ST_IDLE;
      cnt_r <= '0;
      axes_r <= 3'b000;
      pol_r <= 3'b000;
      lat_pulse_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        tap_pkg::ST_IDLE:
          if (sample_valid && any_hit)
          begin
            state_r <= tap_pkg::ST_FIRST;
            cnt_r <= '0;
            axes_r <= hit;
            pol_r <= neg & hit;
          end
        tap_pkg::ST_FIRST, tap_pkg::ST_SECOND:
          if (sample_valid && !any_hit)
          begin
            cnt_r <= '0;
            lat_pulse_r <= 1'b0;
            if (state_r == tap_pkg::ST_FIRST && (dp_en & axes_r) != 3'b000)
              state_r <= tap_pkg::ST_LATENCY;
            else
              state_r <= tap_pkg::ST_IDLE;
          end
          else if (lim_tick)
          begin
            if (cnt_r == tmlt_r)
              state_r <= tap_pkg::ST_RELEASE;
            else
              cnt_r <= cnt_r + 1'b1;
          end
        tap_pkg::ST_LATENCY:
          // pulse starts here are ignored unless abort is armed
          if (abort_en && lat_pulse_r && sample_valid && !any_hit)
          begin
            state_r <= tap_pkg::ST_IDLE;
            lat_pulse_r <= 1'b0;
          end
          else if (long_tick && cnt_r == ltcy_r)
          begin
            state_r <= tap_pkg::ST_WINDOW;
            cnt_r <= '0;
          end
          else
          begin
            if (long_tick)
              cnt_r <= cnt_r + 1'b1;
            if (sample_valid && any_hit)
              lat_pulse_r <= 1'b1;
          end
        tap_pkg::ST_WINDOW:
          if (sample_valid && any_hit)
          begin
            state_r <= tap_pkg::ST_SECOND;
            cnt_r <= '0;
            axes_r <= hit;
            pol_r <= neg & hit;
          end
          else if (long_tick)
          begin
            if (cnt_r == wind_r)
              state_r <= tap_pkg::ST_IDLE;
            else
              cnt_r <= cnt_r + 1'b1;
          end
        tap_pkg::ST_RELEASE:
          // an over-long pulse must end before a new one may start
          if (sample_valid && !any_hit)
            state_r <= tap_pkg::ST_IDLE;
        default:
          state_r <= tap_pkg::ST_IDLE;
      endcase
    end
  end

  // =====================================================================
  // source flags; a new event beats a clearing read in the same cycle
  logic [RW-1:0] ev_word;

  always_comb
  begin
    ev_word = tap_pkg::RESET_VAL;
    ev_word[tap_pkg::SRC_EA] = ev;
    ev_word[tap_pkg::SRC_AX_LSB +: 3] = ev_axes;
    ev_word[tap_pkg::SRC_DPE] = ev_dbl;
    ev_word[tap_pkg::SRC_POL_LSB +: 3] = pol_r & ev_axes;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      src_r <= tap_pkg::RESET_VAL;
    else if (latch_en)
    begin
      // keep the word that first raised the flag until software reads it
      if (ev && (!src_r[tap_pkg::SRC_EA] || src_read))
        src_r <= ev_word;
      else if (src_read)
        src_r <= tap_pkg::RESET_VAL;
    end
    else if (ev)
      src_r <= ev_word;
    else if (sample_valid || src_read)
      src_r <= tap_pkg::RESET_VAL;
  end

endmodule : tap_pulse_detector

// [shared/tap_pkg.sv]
package tap_pkg;

  localparam int unsigned REG_W = 8;
  localparam int unsigned SAMPLE_W = 14;
  localparam int unsigned THR_W = 7;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned MULT_W = 9;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned ADDR_LSB = 2;
  localparam int unsigned DATA_W = 32;

  // =====================================================================
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_CONFIG = 6'h21;
  localparam logic [5:0] IDX_SOURCE = 6'h22;
  localparam logic [5:0] IDX_THR_X = 6'h23;
  localparam logic [5:0] IDX_THR_Y = 6'h24;
  localparam logic [5:0] IDX_THR_Z = 6'h25;
  localparam logic [5:0] IDX_TIME_LIMIT = 6'h26;
  localparam logic [5:0] IDX_LATENCY = 6'h27;
  localparam logic [5:0] IDX_WINDOW = 6'h28;
  localparam logic [5:0] IDX_MODE = 6'h29;
  localparam logic [7:0] RESET_VAL = 8'h00;

  // =====================================================================
  // field positions
  localparam int unsigned CFG_ABORT = 7;
  localparam int unsigned CFG_LATCH = 6;
  localparam int unsigned EN_SINGLE = 0;
  localparam int unsigned EN_DOUBLE = 1;
  localparam int unsigned SRC_EA = 7;
  localparam int unsigned SRC_AX_LSB = 4;
  localparam int unsigned SRC_DPE = 3;
  localparam int unsigned SRC_POL_LSB = 0;
  localparam int unsigned MODE_RATE_LSB = 0;
  localparam int unsigned MODE_PWR_LSB = 3;
  localparam int unsigned MODE_HPF = 5;
  localparam int unsigned MODE_RANGE_LSB = 6;

  // =====================================================================
  // scaling: 8 g in 14 bits is 1024 counts/g, one threshold count is 64
  localparam int unsigned THR_SHIFT = 6;
  localparam logic [1:0] RANGE_2G = 2'h0;
  localparam logic [1:0] RANGE_4G = 2'h1;

  // =====================================================================
  // timing: base step is the finest step of any rate and power mode
  localparam int unsigned CLK_FREQ_MHZ = 10;
  localparam int unsigned BASE_STEP_US = 625;
  localparam int unsigned BASE_STEP_CYCLES = BASE_STEP_US * CLK_FREQ_MHZ;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_LOW_NOISE = 2'b01,
    PWR_HIRES = 2'b10,
    PWR_LOW = 2'b11
  } pwr_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FIRST = 3'b001,
    ST_LATENCY = 3'b010,
    ST_WINDOW = 3'b011,
    ST_SECOND = 3'b100,
    ST_RELEASE = 3'b101
  } state_type;

  // time-limit step in base steps; rate 0 is 800 Hz, 7 is 1.56 Hz
  function automatic logic [MULT_W-1:0] limit_step(input logic [2:0] rate,
    input pwr_type pwr, input logic hpf);
    logic [MULT_W-1:0] s;
    s = 9'h001;
    if (hpf)
    begin
      s = (rate > 3'h4) ? 9'h020 : 9'(9'h002 << rate);
      if (pwr == PWR_HIRES && rate != 3'h0)
        s = 9'h004;
      else if (pwr != PWR_NORMAL && rate > 3'h4)
        s = 9'h080;
      if (pwr == PWR_LOW && rate > 3'h5)
        s = 9'h100;
    end
    else
    begin
      s = (rate > 3'h4) ? 9'h008 : 9'(9'h001 << ((rate == 3'h0) ? 3'h0 :
        rate - 3'h1));
      if (pwr == PWR_HIRES)
        s = 9'h001;
      else if (pwr == PWR_LOW_NOISE && rate > 3'h4)
        s = 9'h020;
      else if (pwr == PWR_LOW)
        s = (rate > 3'h4) ? 9'h040 : 9'(9'h001 << rate);
    end
    return s;
  endfunction : limit_step

endpackage : tap_pkg

// [rtl/tap_step_divider.sv]
`timescale 1ns/1ps
module tap_step_divider #(
  parameter int unsigned CYCLES = tap_pkg::BASE_STEP_CYCLES
)(
  input wire logic mclk,
  input wire logic rstn,
  output logic tick
);

  localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

  if (CYCLES < 2)
  begin : g_chk
    $error("divider needs at least two cycles");
  end

  logic [CW-1:0] cnt_r;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      cnt_r <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (cnt_r == CW'(CYCLES - 1));
      cnt_r <= (cnt_r == CW'(CYCLES - 1)) ? '0 : cnt_r + 1'b1;
    end
  end

endmodule : tap_step_divider

// [rtl/tap_axis_compare.sv]
`timescale 1ns/1ps
module tap_axis_compare (
  input wire logic signed [tap_pkg::SAMPLE_W-1:0] sample,
  input wire logic [1:0] range_select,
  input wire logic [tap_pkg::THR_W-1:0] threshold,
  output logic above,
  output logic negative
);

  logic [tap_pkg::SAMPLE_W-1:0] mag;
  logic [tap_pkg::SAMPLE_W-1:0] mag8g;

  always_comb
  begin
    negative = sample[tap_pkg::SAMPLE_W-1];
    mag = negative ? tap_pkg::SAMPLE_W'(-sample) : sample;
    // rescale to the 8 g weight so the threshold weight never moves
    if (range_select == tap_pkg::RANGE_2G)
      mag8g = mag >> 2;
    else if (range_select == tap_pkg::RANGE_4G)
      mag8g = mag >> 1;
    else
      mag8g = mag;
    above = (mag8g >> tap_pkg::THR_SHIFT) >
      tap_pkg::SAMPLE_W'(threshold);
  end

endmodule : tap_axis_compare

// [tb/tap_pulse_detector_chk.sv]
`timescale 1ns/1ps
module tap_pulse_detector_chk #(
  parameter int unsigned ADDR_W = 8
)(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sample_valid
);
  // ======================================================================
  // read transfers taken at this edge, answered at the next one
  logic rd_tk;
  logic rd_src;
  logic rd_thr;
  assign rd_tk = hsel && hready && htrans == tap_pkg::HTRANS_NONSEQ &&
    !hwrite && hsize == tap_pkg::HSIZE_WORD;
  assign rd_src = rd_tk && haddr[7:2] == tap_pkg::IDX_SOURCE;
  assign rd_thr = rd_tk && haddr[7:2] >= tap_pkg::IDX_THR_X &&
    haddr[7:2] <= tap_pkg::IDX_THR_Z;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // ======================================================================
  // assertions
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  ready_out_a: assert property ($past(rstn) |-> hreadyout)
    else $error("hreadyout low after reset");
  idle_zero_a: assert property (!$past(rd_tk) |-> hrdata == 32'h0)
    else $error("hrdata not zero outside read");
  upper_zero_a: assert property ($past(rd_tk) |-> hrdata[31:8] == 24'h0)
    else $error("hrdata upper bits set");
  thr_top_a: assert property ($past(rd_thr) |-> !hrdata[7])
    else $error("threshold bit 7 set");
  active_any_a: assert property ($past(rd_src) |->
    hrdata[7] == (|hrdata[6:4]))
    else $error("event active disagrees with axis flags");
  pol_flag_a: assert property ($past(rd_src) |->
    (hrdata[2:0] & ~hrdata[6:4]) == 3'h0)
    else $error("polarity on unflagged axis");
  double_evt_a: assert property ($past(rd_src) && hrdata[3] |->
    hrdata[7])
    else $error("double flag without event");
endmodule : tap_pulse_detector_chk

bind tap_pulse_detector tap_pulse_detector_chk #(.ADDR_W(ADDR_W)) u_chk (
  .mclk(mclk),
  .rstn(rstn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hsize(hsize),
  .hready(hready),
  .hrdata(hrdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .sample_valid(sample_valid)
);

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  // ======================================================================
  // rows: byte address, value written, value read back
  localparam logic [23:0] REGS [10] = '{24'h845A5A, 24'h88FF00,
    24'h8CFF7F, 24'h90FF7F, 24'h94FF7F, 24'h98A5A5, 24'h9CA5A5,
    24'hA0A5A5, 24'hA4A5A5, 24'hFCFF00};
  // rows: mode, raw x, filtered y, expected source
  localparam logic [43:0] TAPS [9] = '{
    {8'h80, 14'h013F, 14'h0000, 8'h00}, {8'h80, 14'h0140, 14'h0000, 8'h90},
    {8'h80, 14'h3EC0, 14'h0000, 8'h91}, {8'h40, 14'h027F, 14'h0000, 8'h00},
    {8'h40, 14'h0280, 14'h0000, 8'h90}, {8'h00, 14'h04FF, 14'h0000, 8'h00},
    {8'h00, 14'h0500, 14'h0000, 8'h90}, {8'hA0, 14'h0000, 14'h03E8, 8'hA0},
    {8'h80, 14'h0000, 14'h03E8, 8'h00}};
  localparam logic [13:0] BIG = 14'h03E8;
  logic mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic sample_valid = 1'b0, hreadyout, hresp;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = tap_pkg::HSIZE_WORD;
  logic [31:0] hwdata = 32'h0, hrdata, d;
  logic signed [tap_pkg::SAMPLE_W-1:0] raw_x = '0, raw_y = '0, raw_z = '0;
  logic signed [tap_pkg::SAMPLE_W-1:0] hpf_x = '0, hpf_y = '0, hpf_z = '0;
  int miscompares = 0, checks = 0, cycles = 0;

  always #50 mclk = ~mclk;

  // short base step keeps every interval a few dozen cycles long
  tap_pulse_detector #(.STEP_CYCLES(4), .ADDR_W(8)) u_tap_pulse_detector (
    .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sample_valid(sample_valid), .raw_x(raw_x), .raw_y(raw_y),
    .raw_z(raw_z), .hpf_x(hpf_x), .hpf_y(hpf_y), .hpf_z(hpf_z));

  // ======================================================================
  // tasks
  task conclude;
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  task chk(input string n, input logic [31:0] seen, input logic [31:0] e);
    checks++;
    if (seen !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, e, seen);
    end
  endtask : chk

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= tap_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : xfer

  task wr(input logic [5:0] i, input logic [7:0] v);
    xfer(1'b1, {i, 2'b00}, {24'h0, v});
  endtask : wr

  task rd(input logic [5:0] i, input logic [7:0] e, input string n);
    xfer(1'b0, {i, 2'b00}, 32'h0);
    chk(n, d, {24'h0, e});
  endtask : rd

  task smp(input logic [13:0] x, input logic [13:0] z, input logic [13:0] y);
    @(posedge mclk);
    sample_valid <= 1'b1;
    raw_x <= x;
    raw_z <= z;
    hpf_y <= y;
    @(posedge mclk);
    sample_valid <= 1'b0;
  endtask : smp

  task pulse(input logic [13:0] x, input logic [13:0] z,
    input logic [13:0] y, input int h);
    smp(x, z, y);
    repeat (h) @(posedge mclk);
    smp(14'h0000, 14'h0000, 14'h0000);
  endtask : pulse

  task dbl(input logic [7:0] c, input int gap, input bit mid,
    input logic [7:0] e);
    wr(tap_pkg::IDX_CONFIG, c);
    pulse(BIG, 14'h0000, 14'h0000, 8);
    if (mid)
      pulse(BIG, 14'h0000, 14'h0000, 2);
    repeat (gap) @(posedge mclk);
    pulse(BIG, 14'h0000, 14'h0000, 45);
    repeat (250) @(posedge mclk);
    rd(tap_pkg::IDX_SOURCE, e, "double source");
  endtask : dbl

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      miscompares++;
      conclude();
    end
  end

  // ======================================================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    foreach (REGS[i])
    begin
      xfer(1'b0, REGS[i][23:16], 32'h0);
      chk("reset value", d, 32'h0);
      xfer(1'b1, REGS[i][23:16], {24'h0, REGS[i][15:8]});
      xfer(1'b0, REGS[i][23:16], 32'h0);
      chk("read back", d, {24'h0, REGS[i][7:0]});
    end
    wr(tap_pkg::IDX_THR_X, 8'h04);
    wr(tap_pkg::IDX_THR_Y, 8'h04);
    wr(tap_pkg::IDX_THR_Z, 8'h04);
    wr(tap_pkg::IDX_TIME_LIMIT, 8'h0F);
    wr(tap_pkg::IDX_LATENCY, 8'h02);
    wr(tap_pkg::IDX_WINDOW, 8'h04);
    wr(tap_pkg::IDX_CONFIG, 8'h55);
    foreach (TAPS[i])
    begin
      wr(tap_pkg::IDX_MODE, TAPS[i][43:36]);
      pulse(TAPS[i][35:22], 14'h0000, TAPS[i][21:8], 8);
      repeat (250) @(posedge mclk);
      rd(tap_pkg::IDX_SOURCE, TAPS[i][7:0], "tap source");
    end
    wr(tap_pkg::IDX_MODE, 8'h80);
    pulse(14'h0000, 14'h3C18, 14'h0000, 8);
    repeat (3) smp(14'h0000, 14'h0000, 14'h0000);
    rd(tap_pkg::IDX_SOURCE, 8'hC4, "latched source");
    rd(tap_pkg::IDX_SOURCE, 8'h00, "source after read");
    pulse(BIG, 14'h0000, 14'h0000, 100);
    repeat (250) @(posedge mclk);
    rd(tap_pkg::IDX_SOURCE, 8'h00, "long pulse");
    pulse(BIG, 14'h0000, 14'h0000, 8);
    repeat (250) @(posedge mclk);
    rd(tap_pkg::IDX_SOURCE, 8'h90, "pulse after release");
    dbl(8'h42, 34, 1'b0, 8'h98);
    dbl(8'h42, 150, 1'b0, 8'h00);
    dbl(8'h42, 26, 1'b1, 8'h98);
    dbl(8'hC2, 26, 1'b1, 8'h00);
    wr(tap_pkg::IDX_CONFIG, 8'h15);
    pulse(BIG, 14'h0000, 14'h0000, 8);
    rd(tap_pkg::IDX_SOURCE, 8'h90, "live source");
    repeat (250) @(posedge mclk);
    pulse(BIG, 14'h0000, 14'h0000, 8);
    smp(14'h0000, 14'h0000, 14'h0000);
    rd(tap_pkg::IDX_SOURCE, 8'h00, "live source cleared");
    wr(tap_pkg::IDX_CONFIG, 8'h55);
    pulse(BIG, 14'h0000, 14'h0000, 8);
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(tap_pkg::IDX_SOURCE, 8'h00, "source after reset");
    rd(tap_pkg::IDX_CONFIG, 8'h00, "config after reset");
    conclude();
  end
endmodule : tb
